// File: ssc_pkg.sv
// constants, types and register map of the synchronous serial port control block
package ssc_pkg;

    // register map, byte addresses
    localparam logic [15:0] SSC_ADDR_CTRL_ONE  = 16'h1F96;
    localparam logic [15:0] SSC_ADDR_CTRL_TWO  = 16'h1F97;
    localparam logic [15:0] SSC_ADDR_STATUS    = 16'h1F97;
    localparam logic [15:0] SSC_ADDR_BUF_FIRST = 16'h1F98;
    localparam logic [15:0] SSC_ADDR_BUF_LAST  = 16'h1F9F;
    localparam int          SSC_BUF_WORDS      = 8;

    // reset values
    localparam logic [7:0] SSC_CTRL_ONE_RESET = 8'h00;
    localparam logic [7:0] SSC_CTRL_TWO_RESET = 8'h00;

    // status bit positions
    localparam int SSC_STAT_ACTIVE_BIT = 7;
    localparam int SSC_STAT_SHIFT_BIT  = 6;

    // transfer_mode_sel codes
    localparam logic [2:0] SSC_MODE_TX4  = 3'h2;
    localparam logic [2:0] SSC_MODE_TRX8 = 3'h4;
    localparam logic [2:0] SSC_MODE_RX8  = 3'h5;
    localparam logic [2:0] SSC_MODE_RX4  = 3'h6;

    // serial clock select codes and divider exponents of high_freq_clock
    localparam logic [2:0] SSC_CLK_RESERVED = 3'h6;
    localparam logic [2:0] SSC_CLK_EXTERNAL = 3'h7;
    localparam int SSC_DIV_LOG2_SLOW = 13;
    localparam int SSC_DIV_LOG2_C1   = 8;
    localparam int SSC_DIV_LOG2_C2   = 7;
    localparam int SSC_DIV_LOG2_C3   = 6;
    localparam int SSC_DIV_LOG2_C4   = 5;
    localparam int SSC_DIV_LOG2_C5   = 4;

    // wait field: none, frame of 2, 4 or 8 word times
    localparam logic [1:0] SSC_WAIT_NONE = 2'h0;
    localparam int SSC_HALF_TICKS_PER_WORD = 16;

    // first control register, laid out bit 7 downto 0
    typedef struct packed {
        logic       transferGo;
        logic       abortRequest;
        logic [2:0] transferModeSel;
        logic [2:0] clockSel;
    } ssc_ctrl_one_t;

    // second control register, bits 7..5 ignored
    typedef struct packed {
        logic [2:0] unused;
        logic [1:0] waitSel;
        logic [2:0] wordCount;
    } ssc_ctrl_two_t;

    // cpu side request
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic        wr;
        logic        rd;
    } ssc_bus_req_t;

    typedef enum logic [1:0] {SSC_IDLE, SSC_SHIFT, SSC_GAP} ssc_state_t;

endpackage

// File: ssc_serial_port.sv
// synchronous serial port: control, status, word buffer and shift engine
//
// Function
// - Status register is readable and shares address 01F97H with the second control register.
// - Word buffer occupies eight byte addresses 01F98H to 01F9FH.
// - One to eight words transfer per pass; passes repeat from the lowest address until stop or abort.
// - Transfer interrupt after the programmed word count completes.
// - 8-bit receive modes with internal clock may idle after each word.
// - Wait codes 00 none, 01 two, 10 four, 11 eight word frame.
// - Start bit: 0 stops, 1 starts the serial operation.
// - Abort bit ends the transfer and clears itself afterwards.
// - Mode codes 010, 100, 101, 110; all others reserved.
// - Clock codes 000-101 divide the system clock; 111 external; 110 reserved.
// - Word count 000 means one word up to 111 eight words, from lowest address.
// - 4-bit modes use low nibble; received bytes get zero upper nibble.
// - Transmit starts at lowest address; receive stores ascending.
// - Programmed word count stays unchanged after a transfer.
// - Status bit 7 is one while a transfer is in progress.
// - Status bit 6 is one while the shift register shifts.
// - Transfer flag drops at the end of the word in progress after stop (stop during a wait gap: after the next word), or at abort.
// - Words shift least significant bit first.
// - Transmit on falling clock edge, receive on rising, clock idles high.
`timescale 1ns/1ps

module ssc_serial_port
    import ssc_pkg::*;
#(
    parameter int SLOW_DIV_LOG2 = SSC_DIV_LOG2_SLOW
) (
    input  wire logic         clk,
    input  wire logic         reset_n,
    input  wire ssc_bus_req_t busReq,
    output logic [7:0]        busRdata,
    input  wire logic         prescaleHalve,
    input  wire logic         serialIn,
    input  wire logic         sckIn,
    output logic              sckOut,
    output logic              sckOe,
    output logic              serialOut,
    output logic              transferDoneIrq
);

    // divider reload for half a serial clock period
    function automatic logic [13:0] halfLoad(input logic [2:0] sel, input logic pre);
        int lg;
        case (sel)
            3'h0:    lg = SLOW_DIV_LOG2;
            3'h1:    lg = SSC_DIV_LOG2_C1;
            3'h2:    lg = SSC_DIV_LOG2_C2;
            3'h3:    lg = SSC_DIV_LOG2_C3;
            3'h4:    lg = SSC_DIV_LOG2_C4;
            default: lg = SSC_DIV_LOG2_C5;
        endcase
        return 14'((1 << (lg - 1 + int'(pre))) - 1);
    endfunction

    function automatic logic modeValid(input logic [2:0] m);
        return (m == SSC_MODE_TX4) || (m == SSC_MODE_TRX8) ||
               (m == SSC_MODE_RX8) || (m == SSC_MODE_RX4);
    endfunction

    function automatic logic isBufAddr(input logic [15:0] a);
        return (a >= SSC_ADDR_BUF_FIRST) && (a <= SSC_ADDR_BUF_LAST);
    endfunction

    // pin synchronisers
    logic sinMeta, sinSync, sckMeta, sckSync, sckPrev;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sinMeta <= 1'b1;
            sinSync <= 1'b1;
            sckMeta <= 1'b1;
            sckSync <= 1'b1;
            sckPrev <= 1'b1;
        end else begin
            sinMeta <= serialIn;
            sinSync <= sinMeta;
            sckMeta <= sckIn;
            sckSync <= sckMeta;
            sckPrev <= sckSync;
        end
    end

    // main state
    ssc_state_t    state, next_state;
    ssc_ctrl_one_t ctrlOne, next_ctrlOne;
    ssc_ctrl_two_t ctrlTwo, next_ctrlTwo;
    logic [7:0]    wordBuffer [SSC_BUF_WORDS];
    logic [7:0]    next_wordBuffer [SSC_BUF_WORDS];
    logic [2:0]    wordIdx, next_wordIdx;
    logic [2:0]    bitCnt, next_bitCnt;
    logic [7:0]    txShift, next_txShift;
    logic [7:0]    rxShift, next_rxShift;
    logic [13:0]   divCnt, next_divCnt;
    logic [7:0]    gapCnt, next_gapCnt;
    logic          transferActive, next_transferActive;
    logic          shiftActive, next_shiftActive;
    logic [7:0]    next_busRdata;
    logic          next_sckOut, next_sckOe, next_serialOut, next_transferDoneIrq;

    logic       extClk, nibble, rxMode, txMode, tick, fallEv, riseEv, lastWord;
    logic       storeEv;
    logic [2:0] nextIdx;
    logic [7:0] storeVal;

    always_comb begin
        extClk   = (ctrlOne.clockSel == SSC_CLK_EXTERNAL);
        nibble   = (ctrlOne.transferModeSel == SSC_MODE_TX4) ||
                   (ctrlOne.transferModeSel == SSC_MODE_RX4);
        rxMode   = (ctrlOne.transferModeSel != SSC_MODE_TX4);
        txMode   = (ctrlOne.transferModeSel == SSC_MODE_TX4) ||
                   (ctrlOne.transferModeSel == SSC_MODE_TRX8);
        tick     = (divCnt == 14'h0);
        lastWord = (wordIdx == ctrlTwo.wordCount);
        nextIdx  = lastWord ? 3'h0 : wordIdx + 3'h1;
        storeVal = nibble ? {4'h0, sinSync, rxShift[7:5]} : {sinSync, rxShift[7:1]};
        storeEv  = 1'b0;
        // edges of the serial clock, internal divider or synchronised pin
        if (state != SSC_SHIFT) begin
            fallEv = 1'b0;
            riseEv = 1'b0;
        end else if (extClk) begin
            fallEv = sckPrev && !sckSync;
            riseEv = !sckPrev && sckSync;
        end else begin
            fallEv = tick && sckOut;
            riseEv = tick && !sckOut;
        end

        next_state           = state;
        next_ctrlOne         = ctrlOne;
        next_ctrlTwo         = ctrlTwo;
        next_wordBuffer      = wordBuffer;
        next_wordIdx         = wordIdx;
        next_bitCnt          = bitCnt;
        next_txShift         = txShift;
        next_rxShift         = rxShift;
        next_divCnt          = divCnt;
        next_gapCnt          = gapCnt;
        next_sckOut          = sckOut;
        next_serialOut       = serialOut;
        next_transferDoneIrq = 1'b0;
        next_busRdata        = 8'h00;

        case (state)
            SSC_IDLE: begin
                next_sckOut    = 1'b1;
                next_serialOut = 1'b1;
                if (ctrlOne.transferGo && !ctrlOne.abortRequest &&
                    modeValid(ctrlOne.transferModeSel) &&
                    ctrlOne.clockSel != SSC_CLK_RESERVED) begin
                    next_state   = SSC_SHIFT;
                    next_wordIdx = 3'h0;
                    next_bitCnt  = 3'h0;
                    next_txShift = wordBuffer[0];
                    next_divCnt  = halfLoad(ctrlOne.clockSel, prescaleHalve);
                end
            end
            SSC_SHIFT: begin
                if (!extClk) begin
                    if (tick) begin
                        next_divCnt = halfLoad(ctrlOne.clockSel, prescaleHalve);
                        next_sckOut = !sckOut;
                    end else begin
                        next_divCnt = divCnt - 14'h1;
                    end
                end
                if (fallEv && txMode) begin
                    next_serialOut = txShift[0];
                end
                if (riseEv) begin
                    next_rxShift = {sinSync, rxShift[7:1]};
                    next_txShift = {1'b0, txShift[7:1]};
                    next_bitCnt  = bitCnt + 3'h1;
                    if (bitCnt == (nibble ? 3'h3 : 3'h7)) begin
                        next_bitCnt = 3'h0;
                        if (rxMode) begin
                            storeEv = 1'b1;
                            next_wordBuffer[wordIdx] = storeVal;
                        end
                        next_transferDoneIrq = lastWord;
                        next_wordIdx = nextIdx;
                        next_txShift = wordBuffer[nextIdx];
                        if (!ctrlOne.transferGo) begin
                            next_state = SSC_IDLE;
                        end else if (!extClk && !nibble && rxMode &&
                                     ctrlTwo.waitSel != SSC_WAIT_NONE) begin
                            next_state  = SSC_GAP;
                            next_gapCnt = 8'(SSC_HALF_TICKS_PER_WORD *
                                             ((1 << ctrlTwo.waitSel) - 1) - 1);
                        end
                    end
                end
            end
            SSC_GAP: begin
                // clock parked high for the idle part of the frame
                if (tick) begin
                    next_divCnt = halfLoad(ctrlOne.clockSel, prescaleHalve);
                    if (gapCnt == 8'h0) begin
                        next_state = SSC_SHIFT;
                    end else begin
                        next_gapCnt = gapCnt - 8'h1;
                    end
                end else begin
                    next_divCnt = divCnt - 14'h1;
                end
            end
            default: begin
                next_state = SSC_IDLE;
            end
        endcase

        // abort ends at once and releases its own bit
        if (state != SSC_IDLE && ctrlOne.abortRequest) begin
            next_state                = SSC_IDLE;
            next_ctrlOne.abortRequest = 1'b0;
            next_sckOut               = 1'b1;
            next_serialOut            = 1'b1;
        end

        // cpu access; a receive store to the same byte wins over a cpu write
        if (busReq.wr) begin
            if (busReq.addr == SSC_ADDR_CTRL_ONE) begin
                next_ctrlOne = ssc_ctrl_one_t'(busReq.wdata);
            end else if (busReq.addr == SSC_ADDR_CTRL_TWO) begin
                next_ctrlTwo = ssc_ctrl_two_t'(busReq.wdata);
            end else if (isBufAddr(busReq.addr) && !(storeEv &&
                         busReq.addr[2:0] == wordIdx)) begin
                next_wordBuffer[busReq.addr[2:0]] = busReq.wdata;
            end
        end
        if (busReq.rd) begin
            if (busReq.addr == SSC_ADDR_STATUS) begin
                next_busRdata[SSC_STAT_ACTIVE_BIT] = transferActive;
                next_busRdata[SSC_STAT_SHIFT_BIT]  = shiftActive;
            end else if (isBufAddr(busReq.addr)) begin
                next_busRdata = wordBuffer[busReq.addr[2:0]];
            end
        end

        next_transferActive = (next_state != SSC_IDLE);
        next_shiftActive    = (next_state == SSC_SHIFT);
        next_sckOe = !extClk && modeValid(next_ctrlOne.transferModeSel) &&
                     next_ctrlOne.clockSel != SSC_CLK_RESERVED;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state           <= SSC_IDLE;
            ctrlOne         <= ssc_ctrl_one_t'(SSC_CTRL_ONE_RESET);
            ctrlTwo         <= ssc_ctrl_two_t'(SSC_CTRL_TWO_RESET);
            for (int i = 0; i < SSC_BUF_WORDS; i++) begin
                wordBuffer[i] <= 8'h00;
            end
            wordIdx         <= 3'h0;
            bitCnt          <= 3'h0;
            txShift         <= 8'h00;
            rxShift         <= 8'h00;
            divCnt          <= 14'h0;
            gapCnt          <= 8'h00;
            transferActive  <= 1'b0;
            shiftActive     <= 1'b0;
            busRdata        <= 8'h00;
            sckOut          <= 1'b1;
            sckOe           <= 1'b0;
            serialOut       <= 1'b1;
            transferDoneIrq <= 1'b0;
        end else begin
            state           <= next_state;
            ctrlOne         <= next_ctrlOne;
            ctrlTwo         <= next_ctrlTwo;
            wordBuffer      <= next_wordBuffer;
            wordIdx         <= next_wordIdx;
            bitCnt          <= next_bitCnt;
            txShift         <= next_txShift;
            rxShift         <= next_rxShift;
            divCnt          <= next_divCnt;
            gapCnt          <= next_gapCnt;
            transferActive  <= next_transferActive;
            shiftActive     <= next_shiftActive;
            busRdata        <= next_busRdata;
            sckOut          <= next_sckOut;
            sckOe           <= next_sckOe;
            serialOut       <= next_serialOut;
            transferDoneIrq <= next_transferDoneIrq;
        end
    end

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    sequence seqAbortWrite;
        busReq.wr && busReq.addr == SSC_ADDR_CTRL_ONE && busReq.wdata[6] && transferActive;
    endsequence

    sequence seqAborted;
        !transferActive ##1 !ctrlOne.abortRequest;
    endsequence

    sequence seqLastWordEnd;
        riseEv && lastWord && bitCnt == (nibble ? 3'h3 : 3'h7);
    endsequence

    status_read_a: assert property (
        busReq.rd && busReq.addr == SSC_ADDR_STATUS |=>
            busRdata[7] == $past(transferActive) && busRdata[5:0] == 6'h00)
        else $error("status read does not show transfer flag");

    shift_flag_a: assert property (
        shiftActive |-> transferActive && state == SSC_SHIFT)
        else $error("shift flag without active shift state");

    abort_done_a: assert property (
        seqAbortWrite ##1 !busReq.wr |=> seqAborted)
        else $error("abort did not stop transfer and clear itself");

    reserved_idle_a: assert property (
        state == SSC_IDLE && !modeValid(ctrlOne.transferModeSel) |=>
            !transferActive && serialOut)
        else $error("transfer started on reserved mode");

    done_irq_a: assert property (
        seqLastWordEnd |=> transferDoneIrq ##1 !transferDoneIrq)
        else $error("done interrupt missing after last word");

    nibble_zero_a: assert property (
        storeEv && nibble && !(busReq.wr && busReq.addr[2:0] == wordIdx) |=>
            wordBuffer[$past(wordIdx)][7:4] == 4'h0)
        else $error("upper nibble not cleared on 4-bit receive");

    count_kept_a: assert property (
        !(busReq.wr && busReq.addr == SSC_ADDR_CTRL_TWO) |=> $stable(ctrlTwo))
        else $error("word count changed without a write");

    first_word_a: assert property (
        state == SSC_IDLE ##1 state == SSC_SHIFT |-> wordIdx == 3'h0)
        else $error("transfer did not start at lowest buffer byte");

    clock_idle_a: assert property (
        !transferActive |-> sckOut)
        else $error("serial clock not high while idle");

    stop_end_a: assert property (
        riseEv && bitCnt == (nibble ? 3'h3 : 3'h7) && !ctrlOne.transferGo |=>
            !transferActive)
        else $error("transfer flag kept after stop at word end");

endmodule // ssc_serial_port

// File: ssc_peer_model.sv
// behavioural peripheral on the far side of the serial pins
`timescale 1ns/1ps

module ssc_peer_model (
    input  wire logic        sck,
    input  wire logic        sdo,
    input  wire logic [63:0] txBits,
    input  wire logic        clearIdx,
    output logic             sdi,
    output logic [63:0]      rxBits
);
    int bitIdx;

    initial begin
        sdi    = 1'b1;
        rxBits = '0;
        bitIdx = 0;
    end

    always @(posedge clearIdx) begin
        bitIdx = 0;
    end

    // leading edge: present the next bit, lsb first
    always @(negedge sck) begin
        sdi    = txBits[bitIdx[5:0]];
        bitIdx = bitIdx + 1;
    end

    // trailing edge: capture, then let the line wander once hold time is over
    always @(posedge sck) begin
        rxBits = {sdo, rxBits[63:1]};
        #40 sdi = ~sdi;
    end
endmodule // ssc_peer_model

// File: ssc_serial_port_tb.sv
// self-checking testbench of the synchronous serial port control block
`timescale 1ns/1ps

module ssc_serial_port_tb
    import ssc_pkg::*;
();
    localparam logic [2:0] MODE_TAB [4] = '{SSC_MODE_TX4, SSC_MODE_TRX8,
                                            SSC_MODE_RX8, SSC_MODE_RX4};
    localparam logic [2:0] CLK_TAB  [4] = '{3'h5, 3'h4, 3'h3, 3'h5};
    localparam logic [2:0] WC_TAB   [4] = '{3'h7, 3'h1, 3'h0, 3'h2};
    localparam logic [1:0] WAIT_TAB [4] = '{2'h0, 2'h1, 2'h0, 2'h0};

    logic         clk;
    logic         reset_n;
    ssc_bus_req_t busReq;
    logic [7:0]   busRdata;
    logic         prescaleHalve;
    logic         serialIn;
    logic         sckOut;
    logic         sckOe;
    logic         serialOut;
    logic         transferDoneIrq;
    logic [63:0]  peerTx;
    logic [63:0]  peerRx;
    logic         peerClear;
    logic         extSck;
    logic         linkSck;
    logic         rdSeen;
    logic [7:0]   expQ [$];
    logic [7:0]   bufImage [8];
    int           nFail;
    int           checked;
    integer       seed;

    ssc_serial_port #(.SLOW_DIV_LOG2(5)) ssc_serial_port_i (
        .clk(clk), .reset_n(reset_n), .busReq(busReq), .busRdata(busRdata),
        .prescaleHalve(prescaleHalve), .serialIn(serialIn), .sckIn(extSck),
        .sckOut(sckOut), .sckOe(sckOe), .serialOut(serialOut),
        .transferDoneIrq(transferDoneIrq)
    );

    ssc_peer_model ssc_peer_model_i (
        .sck(linkSck), .sdo(serialOut), .txBits(peerTx), .clearIdx(peerClear),
        .sdi(serialIn), .rxBits(peerRx)
    );

    // the pin carries the block's clock while it drives, else the bench's
    assign linkSck = sckOe ? sckOut : extSck;

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        checked++;
        if (seen !== exp) begin
            nFail++;
            $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic finish_test;
        if (nFail == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // strobe is lowered with one idle cycle after it, so no signal is driven twice per step
    task automatic bus_write(input logic [15:0] a, input logic [7:0] d);
        busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        busReq.wr <= 1'b0;
        @(posedge clk);
    endtask

    task automatic bus_read(input logic [15:0] a, input logic [7:0] exp);
        expQ.push_back(exp);
        busReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        busReq.rd <= 1'b0;
        @(posedge clk);
    endtask

    // read data stands only in the cycle after the strobe
    always @(posedge clk) begin
        if (rdSeen === 1'b1 && expQ.size() > 0) begin
            check(busRdata, expQ.pop_front());
        end
        rdSeen <= busReq.rd;
    end

    initial begin
        #500000;
        nFail++;
        finish_test();
    end

    initial begin
        int         cnt;
        int         nb;
        int         bpw;
        logic [7:0] msk;
        logic [2:0] mode;
        bit         rxd;
        seed          = 32'hCC77;
        reset_n       = 1'b0;
        busReq        = '0;
        prescaleHalve = 1'b0;
        peerTx        = '0;
        peerClear     = 1'b0;
        rdSeen        = 1'b0;
        extSck        = 1'b1;
        repeat (20) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        bus_read(SSC_ADDR_STATUS, 8'h00);
        bus_write(SSC_ADDR_CTRL_TWO, 8'h1F);
        bus_read(SSC_ADDR_STATUS, 8'h00);
        bus_read(SSC_ADDR_BUF_FIRST, 8'h00);
        bus_read(16'h1F95, 8'h00);
        for (int m = 0; m < 4; m++) begin
            for (int pass = 0; pass < 2; pass++) begin
                mode = MODE_TAB[m];
                bpw  = (mode == SSC_MODE_TX4 || mode == SSC_MODE_RX4) ? 4 : 8;
                msk  = (bpw == 4) ? 8'h0F : 8'hFF;
                nb   = (int'(WC_TAB[m]) + 1) * bpw;
                rxd  = (mode != SSC_MODE_TX4);
                prescaleHalve <= 1'($random(seed));
                peerTx        <= {$random(seed), $random(seed)};
                for (int i = 0; i < 8; i++) begin
                    bufImage[i] = 8'($random(seed));
                    bus_write(SSC_ADDR_BUF_FIRST + 16'(i), bufImage[i]);
                end
                bus_write(SSC_ADDR_CTRL_ONE, {2'b01, mode, CLK_TAB[m]});
                // second pass leaves the word count as programmed
                if (pass == 0) begin
                    bus_write(SSC_ADDR_CTRL_TWO, {3'h0, WAIT_TAB[m], WC_TAB[m]});
                end
                peerClear <= 1'b1;
                @(posedge clk);
                peerClear <= 1'b0;
                bus_write(SSC_ADDR_CTRL_ONE, {2'b10, mode, CLK_TAB[m]});
                bus_read(SSC_ADDR_STATUS, 8'hC0);
                check(sckOe, 1'b1);
                cnt = 0;
                while (transferDoneIrq !== 1'b1 && cnt < 20000) begin
                    @(posedge clk);
                    cnt++;
                end
                check(cnt < 20000, 1'b1);
                for (int i = 0; i < 8; i++) begin
                    if (!(mode inside {SSC_MODE_RX8, SSC_MODE_RX4}) && i <= int'(WC_TAB[m])) begin
                        check(8'(peerRx >> (64 - nb + i * bpw)) & msk, bufImage[i] & msk);
                    end
                end
                bus_write(SSC_ADDR_CTRL_ONE, {2'b01, mode, CLK_TAB[m]});
                bus_read(SSC_ADDR_STATUS, 8'h00);
                for (int i = 0; i < 8; i++) begin
                    bus_read(SSC_ADDR_BUF_FIRST + 16'(i), (rxd && i <= int'(WC_TAB[m]))
                             ? (8'(peerTx >> (i * bpw)) & msk) : bufImage[i]);
                end
            end
        end
        // reserved mode, then reserved clock: nothing may start
        for (int r = 0; r < 2; r++) begin
            bus_write(SSC_ADDR_CTRL_ONE, (r == 0) ? {2'b10, 3'h0, 3'h5}
                                                  : {2'b10, SSC_MODE_TRX8, SSC_CLK_RESERVED});
            repeat (40) @(posedge clk);
            bus_read(SSC_ADDR_STATUS, 8'h00);
            check({sckOe, sckOut, serialOut}, 3'b011);
        end
        // one 8-bit word received on a clock driven from outside
        bus_write(SSC_ADDR_CTRL_ONE, {2'b01, SSC_MODE_RX8, SSC_CLK_EXTERNAL});
        bus_write(SSC_ADDR_CTRL_TWO, 8'h00);
        peerClear <= 1'b1;
        @(posedge clk);
        peerClear <= 1'b0;
        bus_write(SSC_ADDR_CTRL_ONE, {2'b10, SSC_MODE_RX8, SSC_CLK_EXTERNAL});
        check(sckOe, 1'b0);
        repeat (8) begin
            repeat (10) @(posedge clk);
            extSck <= 1'b0;
            repeat (10) @(posedge clk);
            extSck <= 1'b1;
        end
        cnt = 0;
        while (transferDoneIrq !== 1'b1 && cnt < 20) begin
            @(posedge clk);
            cnt++;
        end
        check(cnt < 20, 1'b1);
        bus_write(SSC_ADDR_CTRL_ONE, {2'b01, SSC_MODE_RX8, SSC_CLK_EXTERNAL});
        bus_read(SSC_ADDR_STATUS, 8'h00);
        bus_read(SSC_ADDR_BUF_FIRST, 8'(peerTx));
        repeat (2) @(posedge clk);
        finish_test();
    end
endmodule // ssc_serial_port_tb
